//--- design/pdf_forwarder.v
`timescale 1ns/1ps
`include "pdf_map.vh"
module pdf_forwarder #(
    parameter PKT_LEN = 128, // network packet payload size
    parameter EDIT_LEN = 80, // editing buffer size
    parameter TICK_CYC = `PDF_CLK_HZ / `PDF_TICK_HZ,
    parameter MAX_TICKS = `PDF_MAX_MIN * 60 * `PDF_TICK_HZ,
    parameter BRK_CYC = (`PDF_CLK_HZ / 1000) * `PDF_BRK_MS
) (
    input wire clk_sys, // system clock, 20 MHz
    input wire nrst, // synchronous reset, active low
    input wire rxd_pin, // terminal character line, raw
    input wire [7:0] rx_char, // received terminal character
    input wire rx_valid, // character strobe
    input wire [7:0] set_data, // setting write data
    input wire [2:0] set_sel, // setting index 0..4
    input wire set_we, // setting write strobe
    input wire edit_en, // editing setting
    input wire hw_flow, // dte_flow_select_setting: cts mode
    input wire call_up, // call established
    input wire data_mode, // in data transfer mode
    input wire cmd_mode, // in command mode
    input wire escaped, // escaped, awaiting command
    input wire remote_par_msg, // remote parameter message pulse
    input wire remote_brk, // break from remote end pulse
    input wire intr_ack, // interrupt confirmation pulse
    input wire rem_valid, // remote data toward terminal
    input wire net_ready, // network accepts a byte
    output reg [7:0] net_data, // byte to network
    output reg net_valid, // byte strobe
    output reg net_last, // closes a packet
    output reg intr_req, // expedited interrupt packet
    output reg reset_req, // reset request packet
    output reg brk_ind, // break indication message
    output reg recall_req, // leave data transfer
    output reg rem_brk_out, // relay break to terminal
    output reg rem_deliver, // deliver remote data
    output reg [7:0] dte_char, // char to terminal
    output reg dte_char_valid, // char strobe
    output reg cts_q, // clear to send
    output reg svc_en, // service signals enabled
    output reg discard_q, // discard output setting
    output reg [7:0] rd_fwd, // forwarding setting readback
    output reg [7:0] rd_brk // break setting readback
);
    localparam ST_IDLE = 3'h0;
    localparam ST_INTR = 3'h1;
    localparam ST_FWD = 3'h2;
    localparam ST_POST = 3'h3;
    localparam ST_DONE = 3'h4;
    reg [7:0] fwd_sel_q, idle_q, flow_q, svc_q, brk_q;
    reg [7:0] cnt_q; // held characters
    reg [7:0] send_q; // characters left to send
    reg [22:0] tick_q;
    reg [14:0] max_q;
    reg [7:0] idle_cnt_q;
    reg max_run_q, idle_run_q;
    reg [22:0] low_q;
    reg brk_seen_q, s1_q, s2_q, intr_out_q;
    reg [2:0] st_q;
    reg [7:0] act_q;
    reg prompt_q, xoff_q, stop_q;
    wire tick;
    wire [7:0] f_data;
    wire f_valid, f_ready, f_pop;
    wire [2:0] f_lvl;
    wire can_take, fwd_now;
    wire sending;
    wire [1:0] f;
    function [1:0] classify;
        input [7:0] c;
        input [7:0] sel;
        begin
            if (c == `PDF_CH_RECALL || c == `PDF_CH_XON ||
                c == `PDF_CH_XOFF || c == `PDF_CH_DISP ||
                c == `PDF_CH_CDEL || c == `PDF_CH_LDEL) begin
                classify = 2'h2; // higher function claims it
            end else if ((sel == `PDF_FWD_CR && c == `PDF_CH_CR) ||
                (sel == `PDF_FWD_CTRL && (c <= `PDF_CH_CTRL_TOP ||
                c == `PDF_CH_DEL))) begin
                classify = 2'h1;
            end else begin
                classify = 2'h0;
            end
        end
    endfunction
    assign f = classify(rx_char, fwd_sel_q);
    assign sending = (send_q != 8'h00);
    // a command character after escape is not data
    assign can_take = rx_valid && !sending && !escaped && f != 2'h2;
    assign tick = (tick_q == TICK_CYC - 1);
    pdf_fifo #(.WIDTH(8), .DEPTH(4), .AW(2)) u_fifo (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .in_data(rx_char),
        .in_valid(can_take),
        .in_ready(f_ready),
        .out_data(f_data),
        .out_valid(f_valid),
        .out_ready(f_pop),
        .flush(1'b0),
        .level(f_lvl)
    );
    assign f_pop = sending && f_valid && net_ready;
    assign fwd_now = !sending && cnt_q != 8'h00 && (
        (can_take && f == 2'h1) ||
        (!edit_en && cnt_q >= PKT_LEN[7:0]) ||
        (edit_en && cnt_q >= EDIT_LEN[7:0]) ||
        (!f_ready) ||
        (max_run_q && tick && max_q == MAX_TICKS[14:0] - 1'b1) ||
        (idle_run_q && tick && idle_cnt_q == idle_q - 1'b1) ||
        (escaped && rx_valid) ||
        remote_par_msg ||
        st_q == ST_FWD);
    always @(posedge clk_sys) begin
        if (!nrst) begin
            fwd_sel_q <= `PDF_FWD_RST;
            idle_q <= `PDF_IDLE_RST;
            flow_q <= `PDF_FLOW_RST;
            svc_q <= `PDF_SVC_RST;
            brk_q <= `PDF_BRK_RST;
        end else if (set_we) begin
            case (set_sel)
                `PDF_SEL_FWD: fwd_sel_q <= set_data;
                `PDF_SEL_IDLE: idle_q <= set_data;
                `PDF_SEL_FLOW: flow_q <= set_data;
                `PDF_SEL_SVC: svc_q <= set_data;
                `PDF_SEL_BRK: brk_q <= set_data;
                default: fwd_sel_q <= fwd_sel_q;
            endcase
        end
    end
    always @(posedge clk_sys) begin
        if (!nrst) begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            low_q <= 23'h000000;
            brk_seen_q <= 1'b0;
        end else begin
            s1_q <= rxd_pin;
            s2_q <= s1_q;
            brk_seen_q <= 1'b0;
            if (s2_q) begin
                low_q <= 23'h000000;
            end else if (low_q != BRK_CYC[22:0]) begin
                low_q <= low_q + 1'b1;
                if (low_q == BRK_CYC[22:0] - 1'b1) begin
                    brk_seen_q <= 1'b1;
                end
            end
        end
    end
    always @(posedge clk_sys) begin
        if (!nrst) begin
            tick_q <= 23'h000000;
            max_q <= 15'h0000;
            idle_cnt_q <= 8'h00;
            max_run_q <= 1'b0;
            idle_run_q <= 1'b0;
        end else begin
            tick_q <= tick ? 23'h000000 : tick_q + 1'b1;
            if (fwd_now) begin
                max_run_q <= 1'b0;
                idle_run_q <= 1'b0;
            end else begin
                if (can_take && cnt_q == 8'h00) begin
                    max_run_q <= 1'b1;
                    max_q <= 15'h0000;
                end else if (max_run_q && tick) begin
                    max_q <= max_q + 1'b1;
                end
                if (can_take) begin
                    idle_run_q <= !edit_en && idle_q != 8'h00;
                    idle_cnt_q <= 8'h00;
                end else if (idle_run_q && tick) begin
                    idle_cnt_q <= idle_cnt_q + 1'b1;
                end
            end
        end
    end
    always @(posedge clk_sys) begin
        if (!nrst) begin
            st_q <= ST_IDLE;
            act_q <= 8'h00;
            intr_out_q <= 1'b0;
            intr_req <= 1'b0;
            reset_req <= 1'b0;
            brk_ind <= 1'b0;
            recall_req <= 1'b0;
            discard_q <= 1'b0;
        end else begin
            intr_req <= 1'b0;
            reset_req <= 1'b0;
            brk_ind <= 1'b0;
            recall_req <= 1'b0;
            if (intr_ack) begin
                intr_out_q <= 1'b0;
            end
            case (st_q)
                ST_IDLE: begin
                    if (brk_seen_q && call_up && data_mode) begin
                        act_q <= brk_q;
                        discard_q <= brk_q[`PDF_BRK_DISCARD];
                        st_q <= ST_INTR;
                    end
                end
                ST_INTR: begin
                    if (!act_q[`PDF_BRK_INTR]) begin
                        st_q <= ST_FWD;
                    end else if (!intr_out_q || intr_ack) begin
                        intr_req <= 1'b1;
                        intr_out_q <= 1'b1;
                        st_q <= ST_FWD;
                    end
                end
                ST_FWD: begin
                    if (!sending) begin
                        st_q <= ST_POST;
                    end
                end
                ST_POST: begin
                    if (!sending) begin
                        reset_req <= act_q[`PDF_BRK_RESET];
                        brk_ind <= act_q[`PDF_BRK_INDIC];
                        recall_req <= act_q[`PDF_BRK_RECALL];
                        st_q <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    discard_q <= 1'b0;
                    st_q <= ST_IDLE;
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end
    // packet output and held count
    always @(posedge clk_sys) begin
        if (!nrst) begin
            cnt_q <= 8'h00;
            send_q <= 8'h00;
            net_data <= 8'h00;
            net_valid <= 1'b0;
            net_last <= 1'b0;
        end else begin
            net_valid <= f_pop;
            net_data <= f_data;
            net_last <= f_pop && send_q == 8'h01;
            if (fwd_now) begin
                // a refused character never reaches the fifo, so skip it
                send_q <= cnt_q + ((can_take && f_ready) ? 8'h01 : 8'h00);
                cnt_q <= 8'h00;
            end else if (f_pop) begin
                send_q <= send_q - 1'b1;
            end else if (can_take && f_ready) begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end
    always @(posedge clk_sys) begin
        if (!nrst) begin
            cts_q <= 1'b1;
            xoff_q <= 1'b0;
            stop_q <= 1'b0;
            prompt_q <= 1'b0;
            dte_char <= 8'h00;
            dte_char_valid <= 1'b0;
            svc_en <= 1'b1;
            rem_brk_out <= 1'b0;
            rem_deliver <= 1'b0;
            rd_fwd <= `PDF_FWD_RST;
            rd_brk <= `PDF_BRK_RST;
        end else begin
            stop_q <= (f_lvl >= `PDF_STOP_LVL || sending) &&
                ((flow_q == `PDF_FLOW_DATA && data_mode) ||
                (flow_q == `PDF_FLOW_BOTH && (data_mode || cmd_mode)));
            cts_q <= !(hw_flow && stop_q);
            svc_en <= svc_q != `PDF_SVC_NONE;
            rem_brk_out <= remote_brk;
            rem_deliver <= rem_valid && !discard_q;
            rd_fwd <= fwd_sel_q;
            rd_brk <= brk_q;
            dte_char_valid <= 1'b0;
            if (!cmd_mode) begin
                prompt_q <= 1'b0;
            end
            if (!hw_flow && stop_q != xoff_q) begin
                xoff_q <= stop_q;
                dte_char <= stop_q ? `PDF_CH_XOFF : `PDF_CH_XON;
                dte_char_valid <= 1'b1;
            end else if (cmd_mode && !prompt_q &&
                svc_q == `PDF_SVC_PROMPT) begin
                prompt_q <= 1'b1;
                dte_char <= `PDF_CH_STAR;
                dte_char_valid <= 1'b1;
            end
        end
    end
endmodule // pdf_forwarder

//--- shared/pdf_map.vh
`ifndef PDF_MAP_VH
`define PDF_MAP_VH
// setting reset values
`define PDF_FWD_RST 8'h02
`define PDF_IDLE_RST 8'h00
`define PDF_FLOW_RST 8'h02
`define PDF_SVC_RST 8'h05
`define PDF_BRK_RST 8'h00
// setting select codes
`define PDF_SEL_FWD 3'h0
`define PDF_SEL_IDLE 3'h1
`define PDF_SEL_FLOW 3'h2
`define PDF_SEL_SVC 3'h3
`define PDF_SEL_BRK 3'h4
// flow stop threshold, words held
`define PDF_STOP_LVL 3'h3
// forwarding character selections
`define PDF_FWD_NONE 8'h00
`define PDF_FWD_CR 8'h02
`define PDF_FWD_CTRL 8'h7e
// flow control selections
`define PDF_FLOW_NONE 8'h00
`define PDF_FLOW_DATA 8'h01
`define PDF_FLOW_BOTH 8'h02
// service signal selections
`define PDF_SVC_NONE 8'h00
`define PDF_SVC_STD 8'h01
`define PDF_SVC_PROMPT 8'h05
// break action bits
`define PDF_BRK_INTR 0
`define PDF_BRK_RESET 1
`define PDF_BRK_INDIC 2
`define PDF_BRK_RECALL 3
`define PDF_BRK_DISCARD 4
// characters
`define PDF_CH_CR 8'h0d
`define PDF_CH_DEL 8'h7f
`define PDF_CH_CTRL_TOP 8'h1f
`define PDF_CH_XON 8'h11
`define PDF_CH_XOFF 8'h13
`define PDF_CH_STAR 8'h2a
`define PDF_CH_RECALL 8'h10
`define PDF_CH_DISP 8'h12
`define PDF_CH_CDEL 8'h08
`define PDF_CH_LDEL 8'h18
// timing: clock 20 MHz, tick 1/20 s
`define PDF_CLK_HZ 20000000
`define PDF_TICK_HZ 20
`define PDF_BRK_MS 135
`define PDF_MAX_MIN 15
`endif

//--- design/pdf_fifo.v
`timescale 1ns/1ps
module pdf_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    input wire clk_sys, // system clock
    input wire nrst, // sync reset, active low
    input wire [WIDTH-1:0] in_data, // write data
    input wire in_valid, // write request
    output wire in_ready, // space available
    output wire [WIDTH-1:0] out_data, // read data
    output wire out_valid, // data available
    input wire out_ready, // read accept
    input wire flush, // drop all contents
    output wire [AW:0] level // words held
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0] wr_q;
    reg [AW:0] rd_q;
    wire push;
    wire pop;
    assign level = wr_q - rd_q;
    assign in_ready = (level != DEPTH[AW:0]);
    assign out_valid = (level != {(AW+1){1'b0}});
    assign out_data = mem[rd_q[AW-1:0]];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    always @(posedge clk_sys) begin
        if (push) begin
            mem[wr_q[AW-1:0]] <= in_data;
        end
    end
    always @(posedge clk_sys) begin
        if (!nrst || flush) begin
            wr_q <= {(AW+1){1'b0}};
            rd_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end
endmodule // pdf_fifo

//--- testbench/pdf_forwarder_properties.sv
`timescale 1ns/1ps
`include "pdf_map.vh"
module pdf_fwd_checker (
    input wire clk_sys, // clock
    input wire nrst, // reset
    input wire remote_brk, // remote break
    input wire rem_brk_out, // relayed break
    input wire rem_valid, // remote data
    input wire rem_deliver, // delivery
    input wire discard_q, // discard
    input wire net_valid, // byte strobe
    input wire net_last, // packet end
    input wire [7:0] dte_char, // char out
    input wire dte_char_valid, // char strobe
    input wire hw_flow, // cts mode
    input wire cmd_mode, // command mode
    input wire svc_en, // service on
    input wire intr_req, // interrupt
    input wire call_up, // call up
    input wire [7:0] rd_brk // break setting
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    sequence s_relay; ##1 rem_brk_out; endsequence
    sequence s_deliver; ##1 rem_deliver; endsequence
    property p_relay; remote_brk |-> s_relay; endproperty
    property p_deliver; rem_valid && !discard_q |-> s_deliver; endproperty
    property p_drop; discard_q |=> !rem_deliver; endproperty
    property p_last; net_last |-> net_valid; endproperty
    property p_soft;
        dte_char_valid && (dte_char == `PDF_CH_XOFF ||
        dte_char == `PDF_CH_XON) |-> !$past(hw_flow);
    endproperty
    property p_prompt;
        dte_char_valid && dte_char == `PDF_CH_STAR |-> svc_en && cmd_mode;
    endproperty
    property p_brk_call; intr_req |-> call_up; endproperty
    property p_intr_pulse; intr_req |=> !intr_req; endproperty
    property p_discard; $rose(discard_q) |-> rd_brk[`PDF_BRK_DISCARD];
    endproperty
    a_relay: assert property (p_relay) else $error("no relay");
    a_deliver: assert property (p_deliver) else $error("no deliver");
    a_drop: assert property (p_drop) else $error("delivered");
    a_last: assert property (p_last) else $error("last alone");
    a_soft: assert property (p_soft) else $error("soft flow");
    a_prompt: assert property (p_prompt) else $error("prompt");
    a_brk_call: assert property (p_brk_call) else $error("no call");
    a_intr_pulse: assert property (p_intr_pulse) else $error("intr");
    a_discard: assert property (p_discard) else $error("discard");
endmodule // pdf_fwd_checker
bind pdf_forwarder pdf_fwd_checker u_chk (.*);

//--- testbench/pdf_net_sink.sv
`timescale 1ns/1ps
module pdf_net_sink (
    input wire clk_sys, // clock
    input wire nrst, // reset
    input wire [7:0] net_data, // byte
    input wire net_valid, // byte strobe
    input wire net_last, // packet end
    input wire stall, // hold off
    output wire net_ready // accepting
);
    logic [7:0] q[$];
    integer lasts = 0;
    // ready drops at once on stall, as a congested network would
    assign net_ready = nrst & ~stall;
    always @(posedge clk_sys) begin
        if (nrst && net_valid === 1'b1) begin
            q.push_back(net_data);
            if (net_last === 1'b1) lasts = lasts + 1;
        end
    end
endmodule // pdf_net_sink

//--- testbench/test_pdf_forwarder.sv
`timescale 1ns/1ps
`include "pdf_map.vh"
module test_pdf_forwarder;
    logic clk_sys, nrst, rxd_pin, rx_valid, set_we, edit_en, hw_flow;
    logic call_up, data_mode, cmd_mode, escaped, remote_par_msg;
    logic remote_brk, intr_ack, rem_valid, net_ready, stall, net_valid;
    logic net_last, intr_req, reset_req, brk_ind, recall_req, rem_brk_out;
    logic rem_deliver, dte_char_valid, cts_q, svc_en, discard_q;
    logic [7:0] rx_char, set_data, net_data, dte_char, rd_fwd, rd_brk;
    logic [7:0] last_dte;
    logic [2:0] set_sel;
    logic [7:0] codes [6] = '{1, 2, 4, 8, 16, 21};
    integer miscompares = 0, tests_run = 0, cyc = 0, i;
    integer n_intr = 0, n_rst = 0, n_ind = 0, n_rec = 0, n_disc = 0;
    pdf_forwarder #(.TICK_CYC(10), .MAX_TICKS(50), .BRK_CYC(20)) dut (.*);
    pdf_net_sink sink (.*);
    initial begin
        clk_sys = 0;
        forever #25 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        if (intr_req === 1'b1) n_intr = n_intr + 1;
        if (reset_req === 1'b1) n_rst = n_rst + 1;
        if (brk_ind === 1'b1) n_ind = n_ind + 1;
        if (recall_req === 1'b1) n_rec = n_rec + 1;
        if (discard_q === 1'b1) n_disc = n_disc + 1;
        if (dte_char_valid === 1'b1) last_dte = dte_char;
        cyc = cyc + 1;
        if (cyc > 12000) begin
            miscompares = miscompares + 1;
            conclude;
        end
    end
    task conclude;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input string nm, input [31:0] exp, input [31:0] seen);
        tests_run = tests_run + 1;
        if (exp !== seen) begin
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
            miscompares = miscompares + 1;
        end
    endtask
    task tick(input integer n);
        repeat (n) @(posedge clk_sys);
        #2;
    endtask
    task wr(input [2:0] s, input [7:0] d);
        set_sel = s;
        set_data = d;
        set_we = 1;
        tick(1);
        set_we = 0;
        tick(1);
    endtask
    task rx(input [7:0] c);
        rx_char = c;
        rx_valid = 1;
        tick(1);
        rx_valid = 0;
        tick(1);
    endtask
    task brk(input integer n);
        rxd_pin = 0;
        tick(n);
        rxd_pin = 1;
        tick(1);
    endtask
    // waits for n bytes, then checks count, first byte and packet end
    task got(input string nm, input integer n, input [7:0] a,
             input integer lim);
        integer k;
        k = 0;
        while (sink.q.size() < n + (n == 0) && k < lim) begin
            tick(1);
            k = k + 1;
        end
        tick(3);
        chk({nm, " count"}, n, sink.q.size());
        if (n > 0) chk({nm, " first"}, a, sink.q[0]);
        if (n > 0) chk({nm, " end"}, 1, sink.lasts);
        sink.q = {};
        sink.lasts = 0;
        $display("test %s done", nm);
    endtask
    initial begin
        {rxd_pin, call_up, data_mode} = 3'b111;
        {rx_valid, set_we, edit_en, hw_flow, cmd_mode, escaped} = 0;
        {remote_par_msg, remote_brk, intr_ack, rem_valid, stall} = 0;
        {rx_char, set_data, set_sel, last_dte} = 0;
        nrst = 0;
        tick(10);
        nrst = 1;
        chk("fwd reset", `PDF_FWD_RST, rd_fwd);
        chk("brk reset", `PDF_BRK_RST, rd_brk);
        chk("cts reset", 1, cts_q);
        chk("svc reset", 1, svc_en);
        rx("A");
        got("hold", 0, 0, 20);
        rx(`PDF_CH_CR);
        got("cr", 2, "A", 20);
        wr(0, `PDF_FWD_CTRL);
        chk("fwd rb", `PDF_FWD_CTRL, rd_fwd);
        rx("B");
        rx(8'h01);
        got("ctrl", 2, "B", 20);
        rx("C");
        rx(`PDF_CH_DEL);
        got("del", 2, "C", 20);
        rx("D");
        rx(`PDF_CH_RECALL);
        got("prio", 0, 0, 20);
        remote_par_msg = 1;
        tick(1);
        remote_par_msg = 0;
        got("param", 1, "D", 20);
        wr(0, `PDF_FWD_NONE);
        rx("E");
        rx(`PDF_CH_CR);
        got("none", 0, 0, 20);
        rx("F");
        rx("G");
        got("full", 4, "E", 20);
        wr(0, `PDF_FWD_CR);
        wr(1, 8'h03);
        edit_en = 1;
        rx("H");
        got("edit idle", 0, 0, 60);
        edit_en = 0;
        rx("I");
        got("idle", 2, "H", 60);
        edit_en = 1;
        rx("J");
        got("max early", 0, 0, 400);
        got("max", 1, "J", 200);
        edit_en = 0;
        wr(1, 8'h00);
        rx("K");
        escaped = 1;
        rx("x");
        got("escape", 1, "K", 20);
        escaped = 0;
        rx("L");
        brk(15);
        got("short brk", 0, 0, 20);
        call_up = 0;
        brk(25);
        got("no call", 0, 0, 20);
        call_up = 1;
        brk(25);
        got("brk", 1, "L", 30);
        rem_valid = 1;
        for (i = 0; i < 6; i = i + 1) begin
            wr(4, codes[i]);
            chk("brk rb", codes[i], rd_brk);
            {n_intr, n_rst, n_ind, n_rec, n_disc} = 0;
            rx("N");
            brk(25);
            got("action", 1, "N", 40);
            chk("intr", codes[i][0], n_intr);
            chk("reset", codes[i][1], n_rst);
            chk("indic", codes[i][2], n_ind);
            chk("recall", codes[i][3], n_rec);
            chk("discard", codes[i][4], n_disc > 0);
            chk("discard end", 0, discard_q);
            chk("deliver", 1, rem_deliver);
            intr_ack = 1;
            tick(1);
            intr_ack = 0;
            tick(1);
        end
        rem_valid = 0;
        wr(4, 8'h01);
        n_intr = 0;
        rx("O");
        brk(25);
        got("intr a", 1, "O", 40);
        rx("P");
        brk(25);
        got("intr wait", 0, 0, 30);
        chk("intr held", 1, n_intr);
        intr_ack = 1;
        tick(1);
        intr_ack = 0;
        got("intr b", 1, "P", 40);
        chk("intr after", 2, n_intr);
        wr(4, 8'h00);
        for (i = 2; i >= 0; i = i - 1) begin
            wr(2, i == 2 ? `PDF_FLOW_NONE : i == 1 ? `PDF_FLOW_DATA :
               `PDF_FLOW_BOTH);
            hw_flow = (i == 1);
            last_dte = 0;
            rx("Q");
            rx("R");
            rx("S");
            tick(2);
            if (i == 1) chk("cts off", 0, cts_q);
            else chk("xoff", i == 0 ? `PDF_CH_XOFF : 0, last_dte);
            stall = 1;
            rx(`PDF_CH_CR);
            tick(10);
            stall = 0;
            got("flow", 4, "Q", 40);
            if (i == 1) chk("cts on", 1, cts_q);
            else chk("xon", i == 0 ? `PDF_CH_XON : 0, last_dte);
        end
        hw_flow = 0;
        data_mode = 0;
        for (i = 0; i < 3; i = i + 1) begin
            wr(3, i == 0 ? `PDF_SVC_NONE : i == 1 ? `PDF_SVC_STD :
               `PDF_SVC_PROMPT);
            last_dte = 0;
            cmd_mode = 1;
            tick(5);
            chk("prompt", i == 2 ? `PDF_CH_STAR : 0, last_dte);
            chk("svc en", i != 0, svc_en);
            cmd_mode = 0;
            tick(2);
        end
        $display("test svc done");
        data_mode = 1;
        rem_valid = 1;
        remote_brk = 1;
        tick(1);
        chk("relay", 1, rem_brk_out);
        chk("deliver on", 1, rem_deliver);
        {rem_valid, remote_brk} = 0;
        tick(3);
        chk("relay end", 0, rem_brk_out);
        $display("test remote done");
        conclude;
    end
endmodule // test_pdf_forwarder
